// ===== src/agis_defs.vh
`ifndef AGIS_DEFS_VH
`define AGIS_DEFS_VH

// Register addresses
`define AGIS_ADDR_SWAP 8'h24
`define AGIS_ADDR_CGAIN_QUAD 8'h2a
`define AGIS_ADDR_CGAIN_DS 8'h2b
`define AGIS_ADDR_GAIN_CFG 8'h33
`define AGIS_ADDR_FGAIN_BASE 8'h34
`define AGIS_ADDR_FGAIN_LAST 8'h37

// Field positions
`define AGIS_CFG_XSTEP_BIT 0
`define AGIS_CFG_FINE_EN_BIT 1
`define AGIS_SWAP_DUAL_LSB 4
`define AGIS_SWAP_SINGLE_BIT 6
`define AGIS_FGAIN_ODD_LSB 8

// Reset values
`define AGIS_RST_SWAP 7'h00
`define AGIS_RST_CGAIN 16'h0000
`define AGIS_RST_CFG 2'h1
`define AGIS_RST_FGAIN 7'h00

// Channel modes on chan_mode
`define AGIS_MODE_SINGLE 2'h0
`define AGIS_MODE_DUAL 2'h1
`define AGIS_MODE_QUAD 2'h2

// Coarse factors are unsigned with 10 fraction bits
`define AGIS_CG_FRAC 10
`define AGIS_CG_UNITY 17'h00400
// Fine trim: unity is 2^13
`define AGIS_FG_FRAC 13
`define AGIS_FG_UNITY 15'h2000
`define AGIS_FG_NEG_OFS 15'h003f

`endif

// ===== src/agis_gain_swap.v
// How it works
// - With the scale select clear, coarse codes 0 to 12 give 0 to 12 dB.
// - With the scale select set, codes 0 to 13 give the fixed factors.
// - Every one of the eight branches has its own trim code; one shared multiplier applies it.
// - Trim is applied only while the trim enable bit is set.
// - Trim gain is 1 plus a signed code times 2^-13, both ends unity.
// - Trim arithmetic keeps one extra fraction bit before final rounding.
// - One swap bit per channel per mode sits in the swap register.
// - A clear swap bit keeps the positive pin as the non-inverting input.
// - Each channel has its own 4-bit coarse code, one set per mode.
// - Trim codes sit two per register from 0x34; the trim enable sits at 0x33.
`timescale 1ns/1ps
`include "agis_defs.vh"

module agis_gain_swap #(
    parameter W = 12
) (
    input wire clk,
    input wire rst,
    input wire [1:0] chan_mode,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire in_valid,
    output wire in_ready,
    input wire [2:0] in_branch,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [2:0] out_branch,
    output wire [W-1:0] out_data
);
    localparam PW = W + 36;

    reg [6:0] swap_bits;
    reg [15:0] cgain_quad;
    reg [15:0] cgain_ds;
    reg [1:0] gain_cfg;
    reg [6:0] fgain [0:7];

    function [16:0] coarse_factor;
        input xstep;
        input [3:0] code;
        begin
            if (xstep) begin
                case (code)
                    4'h0: coarse_factor = 17'd1024;
                    4'h1: coarse_factor = 17'd1280;
                    4'h2: coarse_factor = 17'd2048;
                    4'h3: coarse_factor = 17'd2560;
                    4'h4: coarse_factor = 17'd4096;
                    4'h5: coarse_factor = 17'd5120;
                    4'h6: coarse_factor = 17'd8192;
                    4'h7: coarse_factor = 17'd10240;
                    4'h8: coarse_factor = 17'd12800;
                    4'h9: coarse_factor = 17'd16384;
                    4'ha: coarse_factor = 17'd20480;
                    4'hb: coarse_factor = 17'd25600;
                    4'hc: coarse_factor = 17'd32768;
                    4'hd: coarse_factor = 17'd51200;
                    default: coarse_factor = `AGIS_CG_UNITY;
                endcase
            end else begin
                case (code)
                    4'h0: coarse_factor = 17'd1024;
                    4'h1: coarse_factor = 17'd1149;
                    4'h2: coarse_factor = 17'd1289;
                    4'h3: coarse_factor = 17'd1446;
                    4'h4: coarse_factor = 17'd1623;
                    4'h5: coarse_factor = 17'd1821;
                    4'h6: coarse_factor = 17'd2043;
                    4'h7: coarse_factor = 17'd2293;
                    4'h8: coarse_factor = 17'd2572;
                    4'h9: coarse_factor = 17'd2886;
                    4'ha: coarse_factor = 17'd3238;
                    4'hb: coarse_factor = 17'd3633;
                    4'hc: coarse_factor = 17'd4077;
                    default: coarse_factor = `AGIS_CG_UNITY;
                endcase
            end
        end
    endfunction

    // Bit 6 set means a negative step of (63 - bits 5..0)
    function [14:0] fine_factor;
        input [6:0] code;
        begin
            if (code[6]) begin
                fine_factor = `AGIS_FG_UNITY - `AGIS_FG_NEG_OFS
                    + {9'h000, code[5:0]};
            end else begin
                fine_factor = `AGIS_FG_UNITY + {9'h000, code[5:0]};
            end
        end
    endfunction

    // Register writes
    integer i;
    always @(posedge clk) begin
        if (rst) begin
            swap_bits <= `AGIS_RST_SWAP;
            cgain_quad <= `AGIS_RST_CGAIN;
            cgain_ds <= `AGIS_RST_CGAIN;
            gain_cfg <= `AGIS_RST_CFG;
            for (i = 0; i < 8; i = i + 1) begin
                fgain[i] <= `AGIS_RST_FGAIN;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `AGIS_ADDR_SWAP: swap_bits <= reg_wdata[6:0];
                `AGIS_ADDR_CGAIN_QUAD: cgain_quad <= reg_wdata;
                `AGIS_ADDR_CGAIN_DS: cgain_ds <= {4'h0, reg_wdata[11:0]};
                `AGIS_ADDR_GAIN_CFG: gain_cfg <= reg_wdata[1:0];
                default: begin
                    if (reg_addr >= `AGIS_ADDR_FGAIN_BASE &&
                            reg_addr <= `AGIS_ADDR_FGAIN_LAST) begin
                        fgain[{reg_addr[1:0], 1'b0}] <= reg_wdata[6:0];
                        fgain[{reg_addr[1:0], 1'b1}] <=
                            reg_wdata[`AGIS_FGAIN_ODD_LSB+6:
                                `AGIS_FGAIN_ODD_LSB];
                    end
                end
            endcase
        end
    end

    // Register reads, one cycle after reg_rd
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `AGIS_ADDR_SWAP: reg_rdata <= {9'h000, swap_bits};
                `AGIS_ADDR_CGAIN_QUAD: reg_rdata <= cgain_quad;
                `AGIS_ADDR_CGAIN_DS: reg_rdata <= cgain_ds;
                `AGIS_ADDR_GAIN_CFG: reg_rdata <= {14'h0000, gain_cfg};
                default: begin
                    if (reg_addr >= `AGIS_ADDR_FGAIN_BASE &&
                            reg_addr <= `AGIS_ADDR_FGAIN_LAST) begin
                        reg_rdata <= {1'b0, fgain[{reg_addr[1:0], 1'b1}],
                            1'b0, fgain[{reg_addr[1:0], 1'b0}]};
                    end else begin
                        reg_rdata <= 16'h0000;
                    end
                end
            endcase
        end
    end

    // Per-sample field selection by channel mode
    reg [3:0] cg_code;
    reg swap_sel;
    always @* begin
        case (chan_mode)
            `AGIS_MODE_SINGLE: begin
                cg_code = cgain_ds[11:8];
                swap_sel = swap_bits[`AGIS_SWAP_SINGLE_BIT];
            end
            `AGIS_MODE_DUAL: begin
                cg_code = in_branch[2] ? cgain_ds[7:4] : cgain_ds[3:0];
                swap_sel = in_branch[2] ? swap_bits[`AGIS_SWAP_DUAL_LSB+1] :
                    swap_bits[`AGIS_SWAP_DUAL_LSB];
            end
            default: begin
                case (in_branch[2:1])
                    2'h0: cg_code = cgain_quad[3:0];
                    2'h1: cg_code = cgain_quad[7:4];
                    2'h2: cg_code = cgain_quad[11:8];
                    default: cg_code = cgain_quad[15:12];
                endcase
                swap_sel = swap_bits[in_branch[2:1]];
            end
        endcase
    end

    // Gain arithmetic
    reg signed [PW-1:0] xs;
    reg signed [PW-1:0] p1;
    reg signed [PW-1:0] p2;
    reg signed [PW-1:0] rnd;
    reg [W-1:0] result;
    always @* begin
        xs = {{(PW-W){in_data[W-1]}}, in_data};
        if (swap_sel) begin
            xs = -xs;
        end
        p1 = xs * $signed({{(PW-17){1'b0}},
            coarse_factor(gain_cfg[`AGIS_CFG_XSTEP_BIT], cg_code)});
        p1 = p1 >>> (`AGIS_CG_FRAC - 1);
        if (gain_cfg[`AGIS_CFG_FINE_EN_BIT]) begin
            p2 = p1 * $signed({{(PW-15){1'b0}},
                fine_factor(fgain[in_branch])});
            p2 = p2 >>> `AGIS_FG_FRAC;
        end else begin
            p2 = p1;
        end
        rnd = (p2 + 1) >>> 1;
        if (rnd > $signed({{(PW-W+1){1'b0}}, {(W-1){1'b1}}})) begin
            result = {1'b0, {(W-1){1'b1}}};
        end else if (rnd < -$signed({{(PW-W){1'b0}}, 1'b1,
                {(W-1){1'b0}}})) begin
            result = {1'b1, {(W-1){1'b0}}};
        end else begin
            result = rnd[W-1:0];
        end
    end

    // Two-entry output buffer
    reg [W-1:0] buf_data [0:1];
    reg [2:0] buf_branch [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push;
    wire pop;
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = buf_data[rd_ptr];
    assign out_branch = buf_branch[rd_ptr];

    always @(posedge clk) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            buf_data[0] <= {W{1'b0}};
            buf_data[1] <= {W{1'b0}};
            buf_branch[0] <= 3'h0;
            buf_branch[1] <= 3'h0;
        end else begin
            if (push) begin
                buf_data[wr_ptr] <= result;
                buf_branch[wr_ptr] <= in_branch;
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule

// ===== tb/agis_gain_swap_chk.sv
`timescale 1ns/1ps
module agis_gain_swap_chk #(parameter W = 12) (
    input wire clk,
    input wire rst,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_rdata,
    input wire in_valid,
    input wire in_ready,
    input wire [2:0] in_branch,
    input wire out_valid,
    input wire out_ready,
    input wire [2:0] out_branch,
    input wire [W-1:0] out_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    out_hold_a: assert property (out_valid && !out_ready |=> out_valid
        && $stable(out_data) && $stable(out_branch)) else $error("moved");
    in_take_a: assert property (in_valid && in_ready && !out_valid |=>
        out_valid && out_branch == $past(in_branch)) else $error("take");
    out_pop_a: assert property (in_ready && out_valid && out_ready && !in_valid
        |=> !out_valid) else $error("pop");
    rd_unmap_a: assert property (reg_rd && reg_addr == 8'h30 |=>
        reg_rdata == 16'h0000) else $error("unmapped");
    rd_cfg_a: assert property (reg_rd && reg_addr == 8'h33 |=>
        reg_rdata[15:2] == 14'h0000) else $error("cfg bits");
    rd_swap_a: assert property (reg_rd && reg_addr == 8'h24 |=>
        reg_rdata[15:7] == 9'h000) else $error("swap bits");
    rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("rdata moved");
    rst_idle_a: assert property ($fell(rst) |-> !out_valid && in_ready
        && reg_rdata == 16'h0000) else $error("reset state");
    cover property (!in_ready);
    cover property (out_valid && !out_ready);
    cover property (reg_rd && reg_addr == 8'h33);
endmodule
bind agis_gain_swap agis_gain_swap_chk #(.W(W)) i_chk (.clk(clk),
    .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_ready(in_ready), .in_branch(in_branch),
    .out_valid(out_valid), .out_ready(out_ready), .out_branch(out_branch),
    .out_data(out_data));

// ===== tb/agis_src_model.sv
`timescale 1ns/1ps
module agis_src_model #(parameter W = 12) (
    input wire clk,
    input wire in_ready,
    output reg in_valid = 1'b0,
    output reg [2:0] in_branch = 3'h0,
    output reg [W-1:0] in_data = {W{1'b0}}
);
    // Holds the word until taken, then scrambles the idle lines
    task send(input [2:0] b, input [W-1:0] d);
        @(negedge clk);
        in_valid = 1'b1;
        in_branch = b;
        in_data = d;
        while (in_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        in_valid = 1'b0;
        in_branch = ~b;
        in_data = ~d;
    endtask
endmodule

// ===== tb/tb_agis_gain_swap.sv
`timescale 1ns/1ps
module tb_agis_gain_swap;
    logic clk, rst, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready;
    logic [1:0] chan_mode;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [2:0] in_branch, out_branch;
    logic [11:0] in_data, out_data;
    logic [14:0] got[$];
    int n_errors = 0;
    int checks_done = 0;
    int cdb[13] = '{1024, 1149, 1289, 1446, 1623, 1821, 2043, 2293, 2572,
        2886, 3238, 3633, 4077};
    int cx[14] = '{1024, 1280, 2048, 2560, 4096, 5120, 8192, 10240, 12800,
        16384, 20480, 25600, 32768, 51200};
    logic [6:0] tc[8] = '{7'h3f, 7'h40, 7'h01, 7'h7e, 7'h00, 7'h7f, 7'h20,
        7'h5f};
    agis_gain_swap #(.W(12)) i_dut (.clk(clk), .rst(rst),
        .chan_mode(chan_mode), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .in_valid(in_valid), .in_ready(in_ready), .in_branch(in_branch),
        .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_branch(out_branch), .out_data(out_data));
    agis_src_model #(.W(12)) i_src (.clk(clk), .in_ready(in_ready),
        .in_valid(in_valid), .in_branch(in_branch), .in_data(in_data));
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [11:0] ey(int x, int c, logic [6:0] f);
        int p;
        p = (x * c) >>> 9;
        if (f[6] | (f != 7'h00))
            p = (p * (f[6] ? 8129 + int'(f[5:0]) :
                8192 + int'(f[5:0]))) >>> 13;
        p = (p + 1) >>> 1;
        p = p > 2047 ? 2047 : (p < -2048 ? -2048 : p);
        return p[11:0];
    endfunction
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk);
        reg_rd = 1'b0;
        chk("reg_rdata", e, reg_rdata);
    endtask
    task xs(input logic [2:0] b, input int x, input logic [11:0] e);
        int n;
        n = 0;
        i_src.send(b, x[11:0]);
        while (got.size() == 0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("out_word", {1'b0, b, e}, {1'b0, got.pop_front()});
    endtask
    task t_regs;
        rd(8'h24, 16'h0000);
        rd(8'h33, 16'h0001);
        wr(8'h30, 16'hffff);
        rd(8'h30, 16'h0000);
        wr(8'h24, 16'hffff);
        rd(8'h24, 16'h007f);
        wr(8'h34, 16'hffff);
        rd(8'h34, 16'h7f7f);
        wr(8'h24, 16'h0000);
        $display("register test done");
    endtask
    task t_coarse;
        wr(8'h33, 16'h0000);
        for (int c = 0; c < 13; c++) begin
            wr(8'h2a, {12'h000, c[3:0]});
            xs(0, 40, ey(40, cdb[c], 7'h00));
        end
        wr(8'h33, 16'h0001);
        for (int c = 0; c < 14; c++) begin
            wr(8'h2a, {c[3:0], 12'h000});
            xs(7, -40, ey(-40, cx[c], 7'h00));
        end
        chan_mode = 2'h1;
        xs(7, -40, ey(-40, 1024, 7'h00));
        wr(8'h2a, 16'h0000);
        $display("coarse test done");
    endtask
    task t_trim;
        wr(8'h33, 16'h0003);
        for (int k = 0; k < 4; k++)
            wr(8'h34 + k[7:0], {1'b0, tc[2 * k + 1], 1'b0, tc[2 * k]});
        for (int b = 0; b < 8; b++)
            xs(b[2:0], 2000, ey(2000, 1024, tc[b]));
        rd(8'h37, 16'h5f20);
        wr(8'h33, 16'h0001);
        xs(0, 2000, ey(2000, 1024, 7'h00));
        $display("trim test done");
    endtask
    task t_buf;
        @(negedge clk) out_ready = 1'b0;
        i_src.send(1, 10);
        i_src.send(2, 20);
        chk("in_ready", 16'h0000, {15'h0000, in_ready});
        @(negedge clk) out_ready = 1'b1;
        repeat (3) @(negedge clk);
        chk("fifo", 16'h100a, {1'b0, got.pop_front()});
        chk("fifo", 16'h2014, {1'b0, got.pop_front()});
        $display("buffer test done");
    endtask
    task t_swap;
        wr(8'h24, 16'h0025);
        xs(4, 300, ey(-300, 1024, 7'h00));
        xs(0, 300, ey(300, 1024, 7'h00));
        @(negedge clk) chan_mode = 2'h2;
        xs(0, 300, ey(-300, 1024, 7'h00));
        xs(2, 300, ey(300, 1024, 7'h00));
        @(negedge clk) chan_mode = 2'h0;
        xs(5, 300, ey(300, 1024, 7'h00));
        $display("swap test done");
    endtask
    task t_ds;
        wr(8'h2b, 16'hf9a5);
        rd(8'h2b, 16'h09a5);
        xs(3, 100, ey(100, cx[9], 7'h00));
        @(negedge clk) chan_mode = 2'h1;
        xs(1, 100, ey(100, cx[5], 7'h00));
        xs(6, 100, ey(-100, cx[10], 7'h00));
        xs(6, 200, ey(-200, cx[10], 7'h00));
        wr(8'h33, 16'h0003);
        xs(1, -100, ey(-100, cx[5], tc[1]));
        $display("dual and single test done");
    endtask
    task t_reset;
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk("out_valid", 16'h0000, {15'h0000, out_valid});
        rd(8'h33, 16'h0001);
        rd(8'h2b, 16'h0000);
        rd(8'h35, 16'h0000);
        $display("reset test done");
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 24'h000000};
        {chan_mode, out_ready} = 3'h5;
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        t_regs();
        t_coarse();
        t_trim();
        t_buf();
        t_swap();
        t_ds();
        t_reset();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    always @(posedge clk)
        if (out_valid === 1'b1 && out_ready === 1'b1)
            got.push_back({out_branch, out_data});
endmodule
